/* rtl/qdi_pkg.sv */
// shared constants and types for the two-wire slave front of the quad converter
package qdi_pkg;

    // ==========================================================
    // timing
    localparam int CLK_MHZ = 40;
    localparam int SPIKE_FS_NS = 50;
    localparam int SPIKE_HS_NS = 10;
    // a spike of this many samples or fewer never reaches the filter output
    localparam logic [1:0] SPIKE_FS_CYC = 2'((SPIKE_FS_NS * CLK_MHZ + 999) / 1000);
    localparam logic [1:0] SPIKE_HS_CYC = 2'((SPIKE_HS_NS * CLK_MHZ + 999) / 1000);
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // ==========================================================
    // addressing and framing
    localparam logic [4:0] ADDR_PREFIX = 5'h13;
    localparam logic [7:0] BCAST_ADDR = 8'h90;
    localparam logic [4:0] MCODE_PREFIX = 5'h01;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam int DAC_BITS = 10;
    localparam int DAC_FULL_SCALE = 1024;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        KIND_CTRL = 2'h0,
        KIND_MSB = 2'h1,
        KIND_LSB = 2'h2
    } qdi_kind_t;

    typedef enum logic [3:0] {
        PH_ADDR = 4'h1,
        PH_WRITE = 4'h2,
        PH_READ = 4'h4,
        PH_IGNORE = 4'h8
    } qdi_phase_t;

    typedef struct packed {
        logic [7:0] data;
        qdi_kind_t kind;
    } qdi_byte_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [DAC_BITS-1:0] code;
    } qdi_update_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic out;
        logic [1:0] cnt;
    } qdi_filt_t;

    typedef struct packed {
        qdi_phase_t phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic ack_due;
        logic data_ack;
        logic data_done;
        qdi_kind_t next_kind;
        qdi_byte_t rx;
        logic [7:0] tx;
        logic tx_lsb;
        logic [7:0] last_msb;
        logic [7:0] last_lsb;
        logic mcode_tog;
    } qdi_link_t;

    typedef struct packed {
        logic sda_oe;
        logic rx_tog;
    } qdi_drive_t;

    typedef struct packed {
        logic [1:0] strap_s1;
        logic [1:0] strap_s2;
        logic [1:0] strap;
        logic [1:0] strap_cnt;
        logic strap_ok;
        logic [2:0] rx_sync;
        logic [2:0] mc_sync;
        logic scl_prev;
        logic sda_prev;
        logic bus_busy;
        logic link_rst_n;
        logic hs_mode;
        logic [7:0] ctrl;
        logic [7:0] msb;
        logic upd_valid;
        qdi_update_t upd;
    } qdi_core_t;

    localparam qdi_filt_t FILT_RST = '{s1: 1'b1, s2: 1'b1, out: 1'b1, cnt: 2'h0};

endpackage : qdi_pkg

/* rtl/qdi_glitch_filter.sv */
// two-flop synchroniser and spike filter for one bus line
`timescale 1ns/1ps
module qdi_glitch_filter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic line_in,
    input wire logic hs_mode,
    output logic line_out
);
    import qdi_pkg::*;

    qdi_filt_t s_reg;
    qdi_filt_t s_next;
    logic [1:0] thr;

    // ==========================================================
    // filter
    always_comb begin
        s_next = s_reg;
        thr = hs_mode ? SPIKE_HS_CYC : SPIKE_FS_CYC; // R11
        s_next.s1 = line_in;
        s_next.s2 = s_reg.s1;
        if (s_reg.s2 == s_reg.out) begin
            s_next.cnt = 2'h0;
        end else if (s_reg.cnt == thr) begin // R17
            s_next.out = s_reg.s2;
            s_next.cnt = 2'h0;
        end else begin
            s_next.cnt = s_reg.cnt + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= FILT_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign line_out = s_reg.out;

    spike_hold_a: assert property ( // R17
        @(posedge clk) disable iff (!rst_n)
        $changed(s_reg.out) |-> $past(s_reg.s2) == s_reg.out && $past(s_reg.s2, 2) == s_reg.out
            && ($past(hs_mode) || $past(s_reg.s2, 3) == s_reg.out)
    ) else $error("filter output changed on a short spike");

endmodule : qdi_glitch_filter

/* rtl/qdi_i2c_slave_front.sv */
// two-wire serial slave front end of a quad 10-bit converter
//
// Functional notes
// R1: code is unsigned 0..1023, full scale 1024
// R2: start is sda falling with scl high
// R3: master keeps sda stable while scl high
// R4: master sends 7-bit address, direction, msb first
// R5: ack whole ninth clock only on address match
// R6: receiver acknowledges each byte next clock
// R7: nine-clock units repeat without limit
// R8: stop releases bus and ends link
// R9: idle after stop until start plus match
// R10: no 10-bit or general call response
// R11: standard, fast and high-speed rates supported
// R12: master code 00001xxx sent at slow rate
// R13: master code not acked, enters high-speed
// R14: repeated start then normal protocol, fast clock
// R15: stop leaves high-speed mode
// R16: master should keep high-speed with repeated starts
// R17: filter spikes 50 ns fast, 10 ns high-speed; only start/stop detection is filtered, the link logic takes raw scl and sda
// R18: open-drain lines, only pull low or release
// R19: master alone drives clock and conditions
// R20: direction 0 is write, 1 is read
// R21: own address 10011, strap pins, direction
// R22: broadcast 10010000 acknowledged for writes only
// R23: control byte once, then msb/lsb pairs
// R24: update at falling edge of ack after lsb
`timescale 1ns/1ps
module qdi_i2c_slave_front (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_link_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic addr_select_hi_pin,
    input wire logic addr_select_lo_pin,
    output logic hs_mode,
    output logic bus_busy,
    output logic upd_valid,
    output qdi_pkg::qdi_update_t upd
);
    import qdi_pkg::*;

    qdi_core_t core_reg;
    qdi_core_t core_next;
    qdi_link_t lk_reg;
    qdi_link_t lk_next;
    qdi_drive_t ng_reg;
    qdi_drive_t ng_next;
    logic [1:0] line_raw;
    logic [1:0] line_filt;
    logic scl_f;
    logic sda_f;
    logic start_det;
    logic stop_det;
    logic rx_edge;
    logic mc_edge;
    logic [7:0] rx_byte;
    logic own_hit;
    logic bcast_hit;
    logic mcode_hit;

    // ==========================================================
    // line filters, both lines share one structure
    assign line_raw = {scl_link_clk, sda_i};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filt
            qdi_glitch_filter u_filt (
                .clk(clk),
                .rst_n(rst_n),
                .line_in(line_raw[gi]),
                .hs_mode(core_reg.hs_mode),
                .line_out(line_filt[gi])
            );
        end
    endgenerate

    assign scl_f = line_filt[1];
    assign sda_f = line_filt[0];

    // ==========================================================
    // system clock side: conditions, mode, update assembly
    assign start_det = scl_f && core_reg.scl_prev && core_reg.sda_prev && !sda_f; // R2 R14
    assign stop_det = scl_f && core_reg.scl_prev && !core_reg.sda_prev && sda_f; // R8
    assign rx_edge = core_reg.rx_sync[2] ^ core_reg.rx_sync[1];
    // the master-code flag is a level cleared by every link reset, only its rise counts
    assign mc_edge = core_reg.mc_sync[1] && !core_reg.mc_sync[2];

    always_comb begin
        core_next = core_reg;
        core_next.upd_valid = 1'b0;
        core_next.strap_s1 = {addr_select_hi_pin, addr_select_lo_pin};
        core_next.strap_s2 = core_reg.strap_s1;
        // pins are caught once after reset, later changes are ignored
        if (!core_reg.strap_ok) begin
            if (core_reg.strap_cnt == STRAP_WAIT) begin // R21
                core_next.strap = core_reg.strap_s2;
                core_next.strap_ok = 1'b1;
            end else begin
                core_next.strap_cnt = core_reg.strap_cnt + 2'h1;
            end
        end
        core_next.rx_sync = {core_reg.rx_sync[1:0], ng_reg.rx_tog};
        core_next.mc_sync = {core_reg.mc_sync[1:0], lk_reg.mcode_tog};
        core_next.scl_prev = scl_f;
        core_next.sda_prev = sda_f;
        if (start_det) begin
            core_next.bus_busy = 1'b1;
        end
        if (stop_det) begin // R9
            core_next.bus_busy = 1'b0;
        end
        // a start pulses the link reset; while idle the link is held in reset
        core_next.link_rst_n = core_next.bus_busy && !start_det; // R2 R8 R9
        if (stop_det) begin // R15
            core_next.hs_mode = 1'b0;
        end
        if (mc_edge) begin // R13
            core_next.hs_mode = 1'b1;
        end
        if (rx_edge) begin
            case (lk_reg.rx.kind)
                KIND_CTRL: core_next.ctrl = lk_reg.rx.data; // R23
                KIND_MSB: core_next.msb = lk_reg.rx.data;
                KIND_LSB: begin // R24
                    core_next.upd_valid = 1'b1;
                    core_next.upd.ctrl = core_reg.ctrl;
                    core_next.upd.code = {core_reg.msb, lk_reg.rx.data[7:6]}; // R1
                end
                default: core_next.msb = core_reg.msb;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_reg <= '0;
        end else begin
            core_reg <= core_next;
        end
    end

    assign hs_mode = core_reg.hs_mode;
    assign bus_busy = core_reg.bus_busy;
    assign upd_valid = core_reg.upd_valid;
    assign upd = core_reg.upd;

    // ==========================================================
    // link side, clocked by scl; sda is stable while scl is high so it is
    // sampled directly on the rising edge. the scl input is not filtered here,
    // a spike on scl would clock a false bit
    assign rx_byte = {lk_reg.shift[6:0], sda_i};
    // strap bits are quasi-static after power-up, read here without a crossing
    assign own_hit = rx_byte[7:1] == {ADDR_PREFIX, core_reg.strap}; // R21
    assign bcast_hit = rx_byte == BCAST_ADDR; // R22
    assign mcode_hit = rx_byte[7:3] == MCODE_PREFIX;

    always_comb begin
        lk_next = lk_reg;
        lk_next.data_done = 1'b0;
        if (lk_reg.bit_cnt != ACK_BIT) begin // R7
            lk_next.shift = rx_byte[7:0];
            lk_next.bit_cnt = lk_reg.bit_cnt + 4'h1;
            if (lk_reg.bit_cnt == LAST_DATA_BIT) begin
                case (lk_reg.phase)
                    PH_ADDR: begin
                        // 10-bit prefixes and the general call match nothing
                        if (own_hit) begin // R5 R10
                            lk_next.ack_due = 1'b1;
                            lk_next.phase = rx_byte[0] ? PH_READ : PH_WRITE; // R20
                            lk_next.next_kind = KIND_CTRL;
                            // last update is quasi-static here; lsb keeps only two bits
                            lk_next.last_msb = core_reg.upd.code[DAC_BITS-1:2];
                            lk_next.last_lsb = {core_reg.upd.code[1:0], 6'h00};
                            lk_next.tx = core_reg.upd.code[DAC_BITS-1:2];
                            lk_next.tx_lsb = 1'b1;
                        end else if (bcast_hit) begin // R22
                            lk_next.ack_due = 1'b1;
                            lk_next.phase = PH_WRITE;
                            lk_next.next_kind = KIND_CTRL;
                        end else if (mcode_hit) begin // R13
                            lk_next.mcode_tog = 1'b1;
                            lk_next.phase = PH_IGNORE;
                        end else begin
                            lk_next.phase = PH_IGNORE;
                        end
                    end
                    PH_WRITE: begin // R6
                        lk_next.ack_due = 1'b1;
                        lk_next.data_ack = 1'b1;
                        lk_next.rx.data = rx_byte;
                        lk_next.rx.kind = lk_reg.next_kind;
                        lk_next.next_kind = (lk_reg.next_kind == KIND_MSB) ? KIND_LSB
                                                                           : KIND_MSB; // R23
                        if (lk_reg.next_kind == KIND_MSB) begin
                            lk_next.last_msb = rx_byte;
                        end
                        if (lk_reg.next_kind == KIND_LSB) begin
                            lk_next.last_lsb = rx_byte;
                        end
                    end
                    PH_READ: lk_next.ack_due = 1'b0;
                    PH_IGNORE: lk_next.ack_due = 1'b0;
                    default: lk_next.phase = PH_IGNORE;
                endcase
            end
        end else begin
            lk_next.bit_cnt = 4'h0;
            lk_next.ack_due = 1'b0;
            lk_next.data_ack = 1'b0;
            lk_next.data_done = lk_reg.data_ack;
            if (lk_reg.phase == PH_READ && !lk_reg.ack_due) begin
                if (sda_i) begin // R6
                    lk_next.phase = PH_IGNORE;
                end else begin
                    lk_next.tx = lk_reg.tx_lsb ? lk_reg.last_lsb : lk_reg.last_msb;
                    lk_next.tx_lsb = ~lk_reg.tx_lsb;
                end
            end
        end
    end

    // reset leaves while scl is high after a start, so no edge races its release
    always_ff @(posedge scl_link_clk or negedge core_reg.link_rst_n) begin
        if (!core_reg.link_rst_n) begin
            lk_reg <= '{phase: PH_ADDR, next_kind: KIND_CTRL, rx: '{data: 8'h00, kind: KIND_CTRL},
                        default: '0};
        end else begin
            lk_reg <= lk_next;
        end
    end

    // ==========================================================
    // sda driver, changes only while scl is low
    always_comb begin
        ng_next = ng_reg;
        ng_next.sda_oe = 1'b0;
        if (lk_reg.bit_cnt == ACK_BIT) begin
            ng_next.sda_oe = lk_reg.ack_due; // R5 R6
        end else if (lk_reg.phase == PH_READ) begin
            ng_next.sda_oe = ~lk_reg.tx[3'h7 - lk_reg.bit_cnt[2:0]];
        end
        if (lk_reg.data_done) begin // R24
            ng_next.rx_tog = ~ng_reg.rx_tog;
        end
    end

    // the toggle survives link resets so the crossing never sees a false edge
    always_ff @(negedge scl_link_clk or negedge rst_n) begin
        if (!rst_n) begin
            ng_reg <= '0;
        end else if (!core_reg.link_rst_n) begin
            ng_reg.sda_oe <= 1'b0; // R8
        end else begin
            ng_reg <= ng_next;
        end
    end

    // open drain: the pin is only ever pulled low, scl is never driven
    assign sda_o = 1'b0; // R18 R19
    assign sda_oe = ng_reg.sda_oe;

    // ==========================================================
    // checks
    start_link_reset_a: assert property ( // R2
        @(posedge clk) disable iff (!rst_n)
        start_det |=> !core_reg.link_rst_n ##1 core_reg.link_rst_n
    ) else $error("start did not restart the link");

    stop_idle_a: assert property ( // R9
        @(posedge clk) disable iff (!rst_n)
        stop_det && !start_det |=> !core_reg.bus_busy && !core_reg.link_rst_n
    ) else $error("stop did not idle the link");

    stop_ends_hs_a: assert property ( // R15
        @(posedge clk) disable iff (!rst_n)
        stop_det && !mc_edge |=> !core_reg.hs_mode
    ) else $error("stop left high-speed mode on");

    mcode_hs_a: assert property ( // R13
        @(posedge clk) disable iff (!rst_n)
        mc_edge |=> core_reg.hs_mode
    ) else $error("master code did not enter high-speed mode");

    update_code_a: assert property ( // R24
        @(posedge clk) disable iff (!rst_n)
        rx_edge && lk_reg.rx.kind == KIND_LSB |=>
            upd_valid && upd.code[1:0] == $past(lk_reg.rx.data[7:6]) ##1 !upd_valid
    ) else $error("lsb byte did not give one update pulse");

    foreign_noack_a: assert property ( // R10
        @(posedge scl_link_clk) disable iff (!core_reg.link_rst_n)
        lk_reg.phase == PH_ADDR && lk_reg.bit_cnt == LAST_DATA_BIT && !own_hit && !bcast_hit
        |=> !lk_reg.ack_due && lk_reg.phase == PH_IGNORE
    ) else $error("foreign address acknowledged");

    own_ack_a: assert property ( // R21
        @(posedge scl_link_clk) disable iff (!core_reg.link_rst_n)
        lk_reg.phase == PH_ADDR && lk_reg.bit_cnt == LAST_DATA_BIT && own_hit
        |=> lk_reg.ack_due && lk_reg.bit_cnt == ACK_BIT
    ) else $error("own address not acknowledged");

    mcode_noack_a: assert property ( // R13
        @(posedge scl_link_clk) disable iff (!core_reg.link_rst_n)
        lk_reg.phase == PH_ADDR && lk_reg.bit_cnt == LAST_DATA_BIT && mcode_hit
        |=> !lk_reg.ack_due && $changed(lk_reg.mcode_tog)
    ) else $error("master code acknowledged or missed");

    unit_wrap_a: assert property ( // R7
        @(posedge scl_link_clk) disable iff (!core_reg.link_rst_n)
        lk_reg.bit_cnt == ACK_BIT |=> lk_reg.bit_cnt == 4'h0
    ) else $error("bit counter did not wrap after ack");

    ack_drive_a: assert property ( // R5
        @(negedge scl_link_clk) disable iff (!core_reg.link_rst_n)
        lk_reg.bit_cnt == ACK_BIT && lk_reg.ack_due |=> ng_reg.sda_oe
    ) else $error("ack not driven in ninth clock");

endmodule : qdi_i2c_slave_front

/* verif/qdi_bus_master.sv */
// behavioural two-wire bus master that drives the slave front
`timescale 1ns/1ps
module qdi_bus_master (
    output logic scl,
    output logic sda_oe,
    input wire logic sda
);
    // ==========================================================
    // bus timing
    // quarter of one scl period; condition and bit edges are spaced by whole multiples of it
    int q_ns = 625;

    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    task automatic set_rate(input logic fast);
        q_ns = fast ? 100 : 625;
    endtask : set_rate

    // ==========================================================
    // conditions and bits
    // also serves as repeated start, entered with scl low
    task automatic start_cond();
        sda_oe = 1'b0;
        #(q_ns);
        scl = 1'b1;
        #(2 * q_ns);
        sda_oe = 1'b1;
        // long hold so the link logic is out of reset before scl falls
        #(2 * q_ns);
        scl = 1'b0;
        #(q_ns);
    endtask : start_cond

    task automatic stop_cond();
        sda_oe = 1'b1;
        #(q_ns);
        scl = 1'b1;
        #(2 * q_ns);
        sda_oe = 1'b0;
        #(4 * q_ns);
    endtask : stop_cond

    task automatic clock_bit(input logic b, output logic got);
        sda_oe = ~b;
        #(q_ns);
        scl = 1'b1;
        #(q_ns);
        got = sda;
        #(q_ns);
        scl = 1'b0;
        #(q_ns);
    endtask : clock_bit

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic d;
        for (int i = 7; i >= 0; i--) clock_bit(b[i], d);
        clock_bit(1'b1, d);
        ack = ~d;
    endtask : send_byte

    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic d;
        for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
        clock_bit(nack, d);
    endtask : recv_byte

    // short low pulse on sda while the bus idles with scl high
    task automatic spike(input int w_ns);
        sda_oe = 1'b1;
        #(w_ns);
        sda_oe = 1'b0;
    endtask : spike
endmodule : qdi_bus_master

/* verif/qdi_i2c_slave_front_bench.sv */
// self-checking bench for the two-wire slave front against a behavioural master
`timescale 1ns/1ps
module qdi_i2c_slave_front_bench;
    import qdi_pkg::*;
    // straps are tied hi=1, lo=0
    localparam logic [7:0] OWN_WR = {ADDR_PREFIX, 2'b10, 1'b0};
    logic clk, rst_n, strap_hi, strap_lo, scl, m_oe;
    logic sda_o, sda_oe, hs_mode, bus_busy, upd_valid;
    qdi_update_t upd, last_upd;
    wire sda_line;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_upd = 0;

    // open-drain wire with pull-up
    assign sda_line = ~((sda_oe & ~sda_o) | m_oe);

    qdi_i2c_slave_front u_dut (
        .clk(clk), .rst_n(rst_n), .scl_link_clk(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_hi_pin(strap_hi),
        .addr_select_lo_pin(strap_lo), .hs_mode(hs_mode), .bus_busy(bus_busy),
        .upd_valid(upd_valid), .upd(upd));
    qdi_bus_master u_master (.scl(scl), .sda_oe(m_oe), .sda(sda_line));

    always @(posedge clk) begin
        if (upd_valid === 1'b1) begin
            n_upd++;
            last_upd = upd;
        end
    end

    // ==========================================================
    // compare and bus helpers
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic snd(input logic [7:0] b, input logic exp_ack);
        logic a;
        u_master.send_byte(b, a);
        chk_bit(a, exp_ack);
    endtask : snd

    task automatic rcv(input logic nack, input logic [7:0] exp);
        logic [7:0] b;
        u_master.recv_byte(nack, b);
        chk_word({10'h0, b}, {10'h0, exp});
    endtask : rcv

    task automatic expect_upd(input int n, input logic [7:0] c, input logic [7:0] m,
                              input logic [7:0] l);
        for (int i = 0; i < 20 && n_upd != n; i++) @(posedge clk);
        chk_bit(n_upd == n, 1'b1);
        chk_word(last_upd, {c, m, l[7:6]});
    endtask : expect_upd

    // ==========================================================
    // scenarios
    task automatic t_spike();
        u_master.spike(40);
        #250;
        chk_bit(bus_busy, 1'b0);
    endtask : t_spike

    task automatic t_write();
        u_master.start_cond();
        chk_bit(bus_busy, 1'b1);
        snd(OWN_WR, 1'b1);
        snd(8'h10, 1'b1);
        snd(8'hff, 1'b1);
        snd(8'hc0, 1'b1);
        expect_upd(1, 8'h10, 8'hff, 8'hc0);
        snd(8'h00, 1'b1);
        chk_bit(n_upd == 1, 1'b1);
        snd(8'h40, 1'b1);
        expect_upd(2, 8'h10, 8'h00, 8'h40);
        chk_bit(sda_o, 1'b0);
        u_master.stop_cond();
        chk_bit(bus_busy, 1'b0);
    endtask : t_write

    task automatic t_read();
        u_master.start_cond();
        snd(OWN_WR | 8'h01, 1'b1);
        rcv(1'b0, 8'h00);
        rcv(1'b0, 8'h40);
        rcv(1'b1, 8'h00);
        chk_bit(sda_oe, 1'b0);
        u_master.stop_cond();
    endtask : t_read

    task automatic t_refuse();
        logic [7:0] bad [4] = '{8'h98, 8'h00, 8'hf0, 8'h91};
        for (int i = 0; i < 4; i++) begin
            u_master.start_cond();
            snd(bad[i], 1'b0);
            snd(BCAST_ADDR, 1'b0);
            u_master.stop_cond();
        end
        u_master.start_cond();
        snd(BCAST_ADDR, 1'b1);
        snd(8'h10, 1'b1);
        u_master.stop_cond();
    endtask : t_refuse

    task automatic t_hs();
        u_master.start_cond();
        snd({MCODE_PREFIX, 3'h5}, 1'b0);
        chk_bit(hs_mode, 1'b1);
        u_master.set_rate(1'b1);
        u_master.start_cond();
        snd(OWN_WR, 1'b1);
        snd(8'h20, 1'b1);
        snd(8'h80, 1'b1);
        snd(8'h00, 1'b1);
        expect_upd(3, 8'h20, 8'h80, 8'h00);
        u_master.start_cond();
        snd(OWN_WR, 1'b1);
        chk_bit(hs_mode, 1'b1);
        u_master.stop_cond();
        chk_bit(hs_mode, 1'b0);
        u_master.set_rate(1'b0);
    endtask : t_hs

    task automatic end_sim();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    // ==========================================================
    // clock, reset, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        strap_hi = 1'b1;
        strap_lo = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        // master edges land between rising clk edges
        #12.5;
        t_spike();
        t_write();
        t_read();
        t_refuse();
        t_hs();
        end_sim();
    end

    // the full sequence needs roughly 22000 cycles
    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
endmodule : qdi_i2c_slave_front_bench
